// ===== src/cb_parity_defs.vh
// constants for the cardbus command/byte-enable and parity block
`ifndef CB_PARITY_DEFS_VH
`define CB_PARITY_DEFS_VH
`define CB_AD_W 32
`define CB_CBE_W 4
`define CB_CBE_RST 4'hf
`define CB_BYTE_W 8
`define CB_BUF_DEPTH 2
`endif

// ===== src/cb_skid_buf.v
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cb_skid_buf #(
  parameter W = 37
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  assign o_in_ready = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem_reg[0] <= {W{1'b0}};
      mem_reg[1] <= {W{1'b0}};
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule // cb_skid_buf
`default_nettype wire

// ===== src/cb_cmd_be_parity.v
// cardbus command/byte-enable lanes and parity for the socket side
`timescale 1ns/1ps
`default_nettype none
`include "cb_parity_defs.vh"
module cb_cmd_be_parity (
  input wire i_clk,
  input wire i_sys_rst,
  // link pins; the inputs come from the card's clock domain, the outputs are registered on i_clk
  input wire i_cclk,
  input wire i_frame_n,
  input wire i_addr_phase,
  input wire i_initiator,
  input wire [`CB_AD_W-1:0] i_cad,
  input wire [`CB_CBE_W-1:0] i_cbe_n,
  output reg [`CB_CBE_W-1:0] o_cbe_n,
  output reg o_cbe_oe,
  input wire i_cpar,
  output reg o_cpar,
  output reg o_cpar_oe,
  output reg o_perr_n,
  output reg o_perr_oe,
  // controller side, initiator request
  input wire i_req_valid,
  output wire o_req_ready,
  input wire i_req_addr_phase,
  input wire [`CB_CBE_W-1:0] i_req_cbe,
  input wire [`CB_AD_W-1:0] i_req_ad,
  // controller side, target data out
  output wire o_rx_valid,
  input wire i_rx_ready,
  output wire [`CB_AD_W-1:0] o_rx_data,
  output wire [`CB_CBE_W-1:0] o_rx_be,
  output wire o_rx_addr_phase,
  // status
  output reg o_perr_flag,
  input wire i_perr_clr
);
  localparam ST_IDLE = 1'b0;
  localparam ST_PAR = 1'b1;
  localparam BW = `CB_AD_W + `CB_CBE_W + 1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // data lanes are only read at a sync'd link edge, half a link clock after
  // they settled, so bits that resolve on different cycles cannot tear a word
  reg cclk_sync1_reg;
  reg cclk_sync2_reg;
  reg frame_n_sync1_reg;
  reg frame_n_sync2_reg;
  reg addr_sync1_reg;
  reg addr_sync2_reg;
  reg init_sync1_reg;
  reg init_sync2_reg;
  reg cpar_sync1_reg;
  reg cpar_sync2_reg;
  reg [`CB_AD_W-1:0] cad_sync1_reg;
  reg [`CB_AD_W-1:0] cad_sync2_reg;
  reg [`CB_CBE_W-1:0] cbe_n_sync1_reg;
  reg [`CB_CBE_W-1:0] cbe_n_sync2_reg;
  reg cclk_d_reg;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // idle levels, so no false edge or frame follows reset
      cclk_sync1_reg <= 1'b0;
      cclk_sync2_reg <= 1'b0;
      frame_n_sync1_reg <= 1'b1;
      frame_n_sync2_reg <= 1'b1;
      addr_sync1_reg <= 1'b0;
      addr_sync2_reg <= 1'b0;
      init_sync1_reg <= 1'b0;
      init_sync2_reg <= 1'b0;
      cpar_sync1_reg <= 1'b0;
      cpar_sync2_reg <= 1'b0;
      cad_sync1_reg <= {`CB_AD_W{1'b0}};
      cad_sync2_reg <= {`CB_AD_W{1'b0}};
      cbe_n_sync1_reg <= `CB_CBE_RST;
      cbe_n_sync2_reg <= `CB_CBE_RST;
      cclk_d_reg <= 1'b0;
    end else begin
      cclk_sync1_reg <= i_cclk;
      cclk_sync2_reg <= cclk_sync1_reg;
      frame_n_sync1_reg <= i_frame_n;
      frame_n_sync2_reg <= frame_n_sync1_reg;
      addr_sync1_reg <= i_addr_phase;
      addr_sync2_reg <= addr_sync1_reg;
      init_sync1_reg <= i_initiator;
      init_sync2_reg <= init_sync1_reg;
      cpar_sync1_reg <= i_cpar;
      cpar_sync2_reg <= cpar_sync1_reg;
      cad_sync1_reg <= i_cad;
      cad_sync2_reg <= cad_sync1_reg;
      cbe_n_sync1_reg <= i_cbe_n;
      cbe_n_sync2_reg <= cbe_n_sync1_reg;
      cclk_d_reg <= cclk_sync2_reg;
    end
  end
  wire cclk_s = cclk_sync2_reg;
  wire frame_act = ~frame_n_sync2_reg;
  wire addr_s = addr_sync2_reg;
  wire init_s = init_sync2_reg;
  wire cpar_s = cpar_sync2_reg;
  wire [`CB_AD_W-1:0] cad_s = cad_sync2_reg;
  wire [`CB_CBE_W-1:0] cbe_n_s = cbe_n_sync2_reg;
  wire cclk_rise = cclk_s & ~cclk_d_reg;

  // ----------------------------------------
  // initiator: drive lines and parity
  // ----------------------------------------
  reg state_reg;
  reg par_next;
  // the request is held until a link edge takes it, so the source stalls
  assign o_req_ready = cclk_rise;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cbe_n <= `CB_CBE_RST;
      o_cbe_oe <= 1'b0;
      o_cpar <= 1'b0;
      o_cpar_oe <= 1'b0;
      state_reg <= ST_IDLE;
    end else if (cclk_rise) begin
      // parity for the previous phase goes out one link clock late;
      // a stopped link clock holds the last one back until the next edge
      case (state_reg)
        ST_PAR: begin
          o_cpar <= par_next;
          o_cpar_oe <= 1'b1;
        end
        default: begin
          o_cpar_oe <= 1'b0;
        end
      endcase
      if (i_req_valid) begin
        // same four lines carry command or enables by phase
        o_cbe_n <= ~i_req_cbe;
        o_cbe_oe <= 1'b1;
        state_reg <= ST_PAR;
      end else begin
        o_cbe_oe <= 1'b0;
        state_reg <= ST_IDLE;
      end
    end
  end
  reg [`CB_AD_W-1:0] tx_ad_reg;
  reg [`CB_CBE_W-1:0] tx_cbe_n_reg;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_ad_reg <= {`CB_AD_W{1'b0}};
      tx_cbe_n_reg <= `CB_CBE_RST;
    end else if (cclk_rise & i_req_valid) begin
      tx_ad_reg <= i_req_ad;
      tx_cbe_n_reg <= ~i_req_cbe;
    end
  end
  // parity taken from the captured word, so it matches what the lines carried
  always @* begin
    par_next = ^{tx_ad_reg, tx_cbe_n_reg};
  end

  // ----------------------------------------
  // target: capture, check parity
  // ----------------------------------------
  reg chk_pend_reg;
  reg chk_par_reg;
  reg rx_push;
  reg [BW-1:0] rx_word;
  always @* begin
    rx_push = cclk_rise & frame_act & ~init_s;
    // in data phases, bytes whose enable is off are zeroed before the user sees them
    rx_word = {addr_s, cad_s, ~cbe_n_s};
  end
  wire [`CB_AD_W-1:0] be_mask;
  genvar g;
  generate
    for (g = 0; g < `CB_CBE_W; g = g + 1) begin : g_lane
      // line n qualifies byte n
      assign be_mask[g*`CB_BYTE_W +: `CB_BYTE_W] = {`CB_BYTE_W{~cbe_n_s[g] | addr_s}};
    end
  endgenerate
  wire perr_hit = cclk_rise & chk_pend_reg & (chk_par_reg != cpar_s);
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chk_pend_reg <= 1'b0;
      chk_par_reg <= 1'b0;
      o_perr_n <= 1'b1;
      o_perr_oe <= 1'b0;
      o_perr_flag <= 1'b0;
    end else begin
      if (cclk_rise) begin
        chk_pend_reg <= rx_push;
        chk_par_reg <= ^{cad_s, cbe_n_s};
        o_perr_n <= ~perr_hit;
        o_perr_oe <= perr_hit | ~o_perr_n;
      end
      // set wins over clear
      if (perr_hit) begin
        o_perr_flag <= 1'b1;
      end else if (i_perr_clr) begin
        o_perr_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  wire [BW-1:0] buf_out;
  cb_skid_buf #(.W(BW)) u_buf (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(rx_push),
    .o_in_ready(),
    .i_in_data({rx_word[BW-1], rx_word[BW-2:`CB_CBE_W] & be_mask, rx_word[`CB_CBE_W-1:0]}),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(buf_out)
  );
  assign o_rx_addr_phase = buf_out[BW-1];
  assign o_rx_data = buf_out[BW-2:`CB_CBE_W];
  assign o_rx_be = buf_out[`CB_CBE_W-1:0];
endmodule // cb_cmd_be_parity
`default_nettype wire

// ===== testbench/cb_props.sv
// assertions on the cardbus lane and parity block
`timescale 1ns/1ps
`default_nettype none
module cb_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic i_req_addr_phase,
  input wire logic o_cbe_oe,
  input wire logic o_cpar,
  input wire logic o_cpar_oe,
  input wire logic o_perr_n,
  input wire logic o_perr_oe,
  input wire logic o_perr_flag,
  input wire logic i_perr_clr,
  input wire logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic o_rx_addr_phase,
  input wire logic [3:0] i_req_cbe,
  input wire logic [3:0] o_cbe_n,
  input wire logic [3:0] o_rx_be,
  input wire logic [31:0] i_req_ad,
  input wire logic [31:0] o_rx_data
);
  logic [35:0] w;
  wire [31:0] m = {{8{o_rx_be[3]}}, {8{o_rx_be[2]}}, {8{o_rx_be[1]}}, {8{o_rx_be[0]}}};
  // word as it sits on the wires, so parity is checked like the far side sees it
  always @(posedge i_clk) if (i_req_valid && o_req_ready) w <= {i_req_ad, ~i_req_cbe};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_cbe_take: assert property (i_req_valid && o_req_ready |=> o_cbe_oe
    && o_cbe_n == ~$past(i_req_cbe)) else $error("lane value wrong");
  chk_par_value: assert property (o_req_ready ##1 o_cpar_oe |-> o_cpar == ^$past(w))
    else $error("parity wrong");
  chk_par_late: assert property ($rose(o_cpar_oe) |-> $past(o_cbe_oe))
    else $error("parity early");
  chk_perr_flag: assert property ($fell(o_perr_n) |-> o_perr_flag)
    else $error("flag missing");
  chk_perr_drive: assert property (!o_perr_n |-> o_perr_oe) else $error("error undriven");
  chk_flag_hold: assert property (o_perr_flag && !i_perr_clr |=> o_perr_flag)
    else $error("flag lost");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("word lost");
  chk_rx_mask: assert property (o_rx_valid && !o_rx_addr_phase |-> (o_rx_data & m) == o_rx_data)
    else $error("lane not masked");
  cover property (o_perr_flag);
  cover property (o_cpar_oe);
  cover property (o_rx_valid && !i_rx_ready);
  cover property (i_req_valid && o_req_ready && i_req_addr_phase);
endmodule // cb_props
bind cb_cmd_be_parity cb_props cb_props_i (.i_clk, .i_sys_rst, .i_req_valid, .o_req_ready,
  .i_req_addr_phase,
  .o_cbe_oe, .o_cpar, .o_cpar_oe, .o_perr_n, .o_perr_oe, .o_perr_flag, .i_perr_clr,
  .o_rx_valid, .i_rx_ready, .o_rx_addr_phase, .i_req_cbe, .o_cbe_n, .o_rx_be, .i_req_ad,
  .o_rx_data);
`default_nettype wire

// ===== testbench/cb_card_model.sv
// card model driving the link lanes
`timescale 1ns/1ps
`default_nettype none
module cb_card_model (
  output logic cclk,
  output logic frame_n,
  output logic addr_ph,
  output logic cpar,
  output logic [31:0] cad,
  output logic [3:0] cbe_n
);
  logic pend = 1'b0;
  initial {cclk, frame_n, addr_ph, cpar, cad, cbe_n} = {4'h4, 36'hf};
  // clock runs only inside frames
  task automatic cyc(input logic a, input logic [35:0] v, input logic bad);
    frame_n = 1'b0;
    addr_ph = a;
    {cad, cbe_n} = v;
    cpar = pend;
    #62.5 cclk = 1'b1;
    #62.5 cclk = 1'b0;
    pend = ^v ^ bad;
  endtask
  task automatic stop();
    {frame_n, cpar, cad, cbe_n} = {1'b1, ~{cpar, cad, cbe_n}};
  endtask
endmodule // cb_card_model
`default_nettype wire

// ===== testbench/testbench.sv
// bench for the lane and parity block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 0, i_sys_rst = 1, i_initiator = 0, i_req_valid = 0, i_req_addr_phase = 0;
  logic i_rx_ready = 1, i_perr_clr = 0, stall_rx = 0, o_req_ready, o_cbe_oe, o_cpar, o_cpar_oe;
  logic o_perr_n, o_perr_oe, o_rx_valid, o_rx_addr_phase, o_perr_flag, cclk, frame_n, ap, cpar;
  logic [3:0] i_req_cbe = 4'h0, cbe_n, o_cbe_n, o_rx_be;
  logic [31:0] i_req_ad = 32'h0, cad, o_rx_data;
  logic [36:0] q[$];
  logic [3:0] cq[$], pq[$];
  logic tick_d = 0, perr_d = 1;
  int perr_cnt = 0;
  int mismatches = 0, compares = 0;
  always #2.5 i_clk = ~i_clk;
  cb_card_model cb_card_model_i (.cclk, .frame_n, .addr_ph(ap), .cpar, .cad, .cbe_n);
  cb_cmd_be_parity cb_cmd_be_parity_i (.i_clk, .i_sys_rst, .i_cclk(cclk), .i_frame_n(frame_n),
    .i_addr_phase(ap), .i_initiator, .i_cad(cad), .i_cbe_n(cbe_n), .o_cbe_n, .o_cbe_oe,
    .i_cpar(cpar), .o_cpar, .o_cpar_oe, .o_perr_n, .o_perr_oe, .i_req_valid, .o_req_ready,
    .i_req_addr_phase, .i_req_cbe, .i_req_ad, .o_rx_valid, .i_rx_ready, .o_rx_data, .o_rx_be,
    .o_rx_addr_phase, .o_perr_flag, .i_perr_clr);
  task automatic cmp(input logic [36:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_tx(input logic [3:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one card phase; a full buffer keeps its two oldest words
  task automatic send(input logic a, bad, stall);
    logic [35:0] v;
    logic [3:0] b;
    v = {$urandom, 4'($urandom)};
    b = ~v[3:0];
    if (!stall || q.size() < 2) q.push_back({a, b, a ? v[35:4] : v[35:4] &
      {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}}});
    cb_card_model_i.cyc(a, v, bad);
  endtask
  task automatic req(input logic a);
    logic [3:0] c;
    logic [31:0] d;
    logic ok;
    c = 4'($urandom);
    d = $urandom;
    ok = 1'b0;
    @(posedge i_clk);
    {i_req_valid, i_req_addr_phase, i_req_cbe, i_req_ad} <= {1'b1, a, c, d};
    repeat (100) begin
      @(posedge i_clk);
      if (o_req_ready === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    i_req_valid <= 1'b0;
    if (ok) begin
      cq.push_back(~c);
      pq.push_back({3'h0, ^{d, ~c}});
    end else mismatches++;
  endtask
  always @(posedge i_clk) begin
    i_rx_ready <= stall_rx ? 1'b0 : 1'($urandom);
    tick_d <= (o_req_ready === 1'b1);
    perr_d <= o_perr_n;
    if (perr_d === 1'b1 && o_perr_n === 1'b0 && o_perr_oe === 1'b1) perr_cnt++;
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1)
      cmp({o_rx_addr_phase, o_rx_be, o_rx_data}, q.size() ? q.pop_front() : 37'h0);
    if (tick_d && o_cbe_oe === 1'b1)
      cmp_tx(o_cbe_n, cq.size() ? cq.pop_front() : 4'h0);
    if (tick_d && o_cpar_oe === 1'b1)
      cmp_tx({3'h0, o_cpar}, pq.size() ? pq.pop_front() : 4'h0);
  end
  initial begin
    void'($urandom(55));
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < 8; i++) send(i == 0, 0, 0);
    cmp(o_perr_flag, 37'h0);
    cmp(perr_cnt, 37'h0);
    for (int i = 0; i < 4; i++) send(0, i == 1, 0);
    cb_card_model_i.stop();
    repeat (20) @(posedge i_clk);
    cmp(o_perr_flag, 37'h1);
    cmp(perr_cnt, 37'h1);
    i_perr_clr <= 1'b1;
    @(posedge i_clk) i_perr_clr <= 1'b0;
    repeat (2) @(posedge i_clk);
    cmp(o_perr_flag, 37'h0);
    stall_rx <= 1'b1;
    for (int i = 0; i < 4; i++) send(0, 0, 1);
    cb_card_model_i.stop();
    @(posedge i_clk) stall_rx <= 1'b0;
    repeat (60) @(posedge i_clk);
    cmp(q.size(), 37'h0);
    i_initiator <= 1'b1;
    fork
      for (int i = 0; i < 10; i++) cb_card_model_i.cyc(0, {$urandom, 4'($urandom)}, 0);
      for (int i = 0; i < 8; i++) req(i == 0);
    join
    cb_card_model_i.stop();
    repeat (100) @(posedge i_clk);
    cmp(cq.size() + pq.size(), 37'h0);
    cmp(perr_cnt, 37'h1);
    wrap_up();
  end
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
